// File: prfir_top.v
// Result, status, differential interrupt and sample queue logic of the
// pressure sensor. Assumes the serial interface, the conversion path and the
// control registers outside it share sys_clk; only trigger_pin is a pin.
//
// How it works
// - Routing register: bits 3..0 route empty, watermark, full, ready.
// - Latch bit set holds differential flags; cleared, flags track events.
// - Low enable requests an event when differential pressure is below.
// - High enable requests an event when differential pressure is above.
// - Reading the differential flag register clears it.
// - Flags: bit 2 any event, bit 1 low, bit 0 high, rest zero.
// - Sample status updates every sample regardless of read hold.
// - Pressure available sets on new sample, clears on top byte read.
// - Temperature available sets on new sample, clears on high byte read.
// - Pressure overrun sets on sample while available; top byte read clears.
// - Temperature overrun likewise; cleared by high temperature byte read.
// - Pressure is 24-bit two's complement, three bytes, low byte first.
// - Pressure result resets to 02F800h, which is 47.5 hPa at 4096 counts per hPa.
// - Temperature is 16-bit two's complement, low byte then high byte.
// - Mode field: bypass, queue stopping when full, stream dropping oldest.
// - Trigger modes switch stream to queue, or bypass to stream or queue, on trigger low.
// - Mean mode gives moving average of 2..32 samples per watermark.
// - In mean mode queue entries are hidden; reads give the average.
// - Watermark status is one when level reaches watermark threshold.
// - Queue state: bit 6 full, bit 5 empty, bits 4..0 level.
// - Threshold is 16-bit unsigned in two bytes, sixteenths of hPa.
// - Signed solder offset, low byte reset 38h, used in difference.
// - Threshold comparison runs only with differential enable set.
// - Queue stores 32 pressure samples of 24 bits.
// - Queue read moves oldest entry to result; address wraps 2Ah to 28h.

`timescale 1ns/10ps
`include "prfir_map.vh"

module prfir_top #(
    parameter DEPTH_LOG2 = 5,
    parameter PW         = 24,
    parameter TW         = 16
) (
    // Clock and reset.
    input  wire          sys_clk,
    input  wire          rst_b,
    // Register port from the serial interface.
    input  wire [7:0]    reg_addr,
    input  wire          reg_wr,
    input  wire [7:0]    reg_wdata,
    input  wire          reg_rd,
    output reg  [7:0]    reg_rdata,
    output reg           burst_wrap,
    // Samples from the conversion path.
    input  wire          press_strobe,
    input  wire [PW-1:0] press_sample,
    input  wire          temp_strobe,
    input  wire [TW-1:0] temp_sample,
    // Control bits kept in the neighbouring control registers.
    input  wire          differential_enable,
    input  wire          hold_until_both_read,
    input  wire          irq_active_low,
    input  wire          irq_open_drain,
    input  wire [1:0]    irq_pin_select,
    // Trigger pin and interrupt pin.
    input  wire          trigger_pin,
    output reg           event_pin_o,
    output reg           event_pin_oe
);

    localparam DEPTH = 1 << DEPTH_LOG2;
    localparam SW    = PW + DEPTH_LOG2;

    ////////////////////////////////////////////////////////////////////////
    // Functions.
    // Resolves trigger dependent codes to the mode in force right now.
    function [2:0] eff_mode;
        input [2:0] code;
        input       trig;
        begin
            case (code)
                `PRFIR_M_FIFO:     eff_mode = `PRFIR_M_FIFO;
                `PRFIR_M_STREAM:   eff_mode = `PRFIR_M_STREAM;
                `PRFIR_M_STR_FIFO: eff_mode = trig ? `PRFIR_M_STREAM
                                                   : `PRFIR_M_FIFO;
                `PRFIR_M_BYP_STR:  eff_mode = trig ? `PRFIR_M_BYPASS
                                                   : `PRFIR_M_STREAM;
                `PRFIR_M_BYP_FIFO: eff_mode = trig ? `PRFIR_M_BYPASS
                                                   : `PRFIR_M_FIFO;
                `PRFIR_M_MEAN:     eff_mode = `PRFIR_M_MEAN;
                default:           eff_mode = `PRFIR_M_BYPASS;
            endcase
        end
    endfunction

    // Number of set bits; gives log2 of the average length for valid codes.
    function [2:0] ones5;
        input [4:0] v;
        begin
            ones5 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} +
                    {2'b00, v[3]} + {2'b00, v[4]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Software visible state.
    reg  [3:0]        route_q;
    reg  [2:0]        diff_cfg_q;
    reg  [2:0]        diff_flags_q;
    reg               p_avail_q;
    reg               t_avail_q;
    reg               p_ovr_q;
    reg               t_ovr_q;
    reg  [PW-1:0]     press_q;
    reg  [TW-1:0]     temp_q;
    reg  [2:0]        fmode_q;
    reg  [4:0]        wtm_q;
    reg  [15:0]       ths_q;
    reg  [15:0]       offset_q;
    reg               p_lock_q;
    reg               t_lock_q;

    // Queue storage and pointers.
    reg  [PW-1:0]     mem [0:DEPTH-1];
    reg  [DEPTH_LOG2-1:0] wr_ptr_q;
    reg  [DEPTH_LOG2-1:0] rd_ptr_q;
    reg  [DEPTH_LOG2:0]   count_q;
    reg  [SW-1:0]     sum_q;
    reg  [2:0]        prev_mode_q;

    // Trigger pin synchroniser.
    reg               trig_s1_q;
    reg               trig_s2_q;

    ////////////////////////////////////////////////////////////////////////
    // Decode and queue control.
    // Read strobes for the registers whose reads have side effects.
    wire rd_b0   = reg_rd & (reg_addr == `PRFIR_PRESS_B0);
    wire rd_b2   = reg_rd & (reg_addr == `PRFIR_PRESS_B2);
    wire rd_tlo  = reg_rd & (reg_addr == `PRFIR_TEMP_LO);
    wire rd_thi  = reg_rd & (reg_addr == `PRFIR_TEMP_HI);
    wire rd_flg  = reg_rd & (reg_addr == `PRFIR_DIFF_FLAGS);

    wire [2:0] mode_now = eff_mode(fmode_q, trig_s2_q);
    wire is_fifo   = (mode_now == `PRFIR_M_FIFO);
    wire is_stream = (mode_now == `PRFIR_M_STREAM);
    wire is_mean   = (mode_now == `PRFIR_M_MEAN);
    wire is_bypass = (mode_now == `PRFIR_M_BYPASS);
    wire q_read_on = is_fifo | is_stream;
    wire full      = (count_q == DEPTH);
    wire empty     = (count_q == 0);
    wire [DEPTH_LOG2:0] wtm_ext = {1'b0, wtm_q};
    wire wtm_hit   = (count_q >= wtm_ext);

    // Leaving or entering mean mode flushes so the average starts clean.
    wire flush = is_bypass | ((mode_now != prev_mode_q) &
                 (is_mean | (prev_mode_q == `PRFIR_M_MEAN)));

    // Queue mode stops when full; stream and mean keep the newest samples.
    wire push = press_strobe & ~flush &
                ((is_fifo & ~full) | is_stream | is_mean);
    wire pop  = rd_b0 & q_read_on & ~empty & ~flush;
    wire drop = push & full & ~pop;

    // Moving sum over the last N samples, N taken from the watermark.
    wire [DEPTH_LOG2:0]   avg_n   = wtm_ext + 1'b1;
    wire [DEPTH_LOG2-1:0] old_idx = wr_ptr_q - avg_n[DEPTH_LOG2-1:0];
    wire [SW-1:0] new_ext = {{DEPTH_LOG2{press_sample[PW-1]}}, press_sample};
    wire [SW-1:0] old_ext = {{DEPTH_LOG2{mem[old_idx][PW-1]}},
                             mem[old_idx]};
    wire          sub_old = (count_q >= avg_n);
    wire [SW-1:0] sum_nx  = sum_q + new_ext - (sub_old ? old_ext
                                                       : {SW{1'b0}});
    wire [SW-1:0] avg_sh  = $signed(sum_nx) >>> ones5(wtm_q);
    wire [PW-1:0] avg_val = avg_sh[PW-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Differential threshold comparison.
    // Threshold is in sixteenths of hPa, pressure in 1/4096 hPa counts.
    wire signed [PW+1:0] diff_val = $signed({{2{press_sample[PW-1]}},
                                    press_sample}) -
                                    $signed({{(PW-14){offset_q[15]}},
                                    offset_q});
    wire signed [PW+1:0] ths_cnt  = $signed({2'b00, ths_q,
                                    {`PRFIR_THS_SHIFT{1'b0}}});
    wire cmp_go  = press_strobe & differential_enable;
    wire req_hi  = cmp_go & diff_cfg_q[`PRFIR_CFG_HIGH_EN] &
                   (diff_val > ths_cnt);
    wire req_lo  = cmp_go & diff_cfg_q[`PRFIR_CFG_LOW_EN] &
                   (diff_val < -ths_cnt);

    ////////////////////////////////////////////////////////////////////////
    // Trigger pin synchroniser; only the second stage is read.
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
        end else begin
            trig_s1_q <= trigger_pin;
            trig_s2_q <= trig_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host writable configuration.
    // Upper routing bits are reserved; they are not stored and read zero.
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            route_q    <= 4'h0;
            diff_cfg_q <= 3'h0;
            fmode_q    <= 3'h0;
            wtm_q      <= 5'h00;
            ths_q      <= 16'h0000;
            offset_q   <= {`PRFIR_OFFSET_HI_RST, `PRFIR_OFFSET_LO_RST};
        end else if (reg_wr) begin
            case (reg_addr)
                `PRFIR_IRQ_ROUTE:  route_q <= reg_wdata[3:0];
                `PRFIR_DIFF_CFG:   diff_cfg_q <= reg_wdata[2:0];
                `PRFIR_QUEUE_CTRL: begin
                    fmode_q <= reg_wdata[7:5];
                    wtm_q   <= reg_wdata[4:0];
                end
                `PRFIR_THS_LO:     ths_q[7:0]     <= reg_wdata;
                `PRFIR_THS_HI:     ths_q[15:8]    <= reg_wdata;
                `PRFIR_OFFSET_LO:  offset_q[7:0]  <= reg_wdata;
                `PRFIR_OFFSET_HI:  offset_q[15:8] <= reg_wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Differential interrupt flags.
    // A request arriving in the cycle of a clearing read still sets its flag.
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            diff_flags_q <= 3'h0;
        end else if (diff_cfg_q[`PRFIR_CFG_LATCH]) begin
            diff_flags_q[`PRFIR_FLG_HIGH] <= req_hi |
                (diff_flags_q[`PRFIR_FLG_HIGH] & ~rd_flg);
            diff_flags_q[`PRFIR_FLG_LOW]  <= req_lo |
                (diff_flags_q[`PRFIR_FLG_LOW] & ~rd_flg);
            diff_flags_q[`PRFIR_FLG_ANY]  <= req_hi | req_lo |
                (diff_flags_q[`PRFIR_FLG_ANY] & ~rd_flg);
        end else if (cmp_go) begin
            diff_flags_q <= {req_hi | req_lo, req_lo, req_hi};
        end else if (rd_flg) begin
            diff_flags_q <= 3'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample status flags, updated every sample without regard to hold.
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            p_avail_q <= 1'b0;
            t_avail_q <= 1'b0;
            p_ovr_q   <= 1'b0;
            t_ovr_q   <= 1'b0;
        end else begin
            p_avail_q <= press_strobe | (p_avail_q & ~rd_b2);
            t_avail_q <= temp_strobe | (t_avail_q & ~rd_thi);
            p_ovr_q   <= (press_strobe & p_avail_q) |
                         (p_ovr_q & ~rd_b2);
            t_ovr_q   <= (temp_strobe & t_avail_q) |
                         (t_ovr_q & ~rd_thi);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result registers with optional hold between partial reads.
    // The hold keeps bytes of one sample together if the host is slow.
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            press_q  <= `PRFIR_PRESS_RST;
            temp_q   <= {TW{1'b0}};
            p_lock_q <= 1'b0;
            t_lock_q <= 1'b0;
        end else begin
            if (rd_b2)
                p_lock_q <= 1'b0;
            else if (rd_b0 & hold_until_both_read)
                p_lock_q <= 1'b1;
            if (rd_thi)
                t_lock_q <= 1'b0;
            else if (rd_tlo & hold_until_both_read)
                t_lock_q <= 1'b1;
            if (pop)
                press_q <= mem[rd_ptr_q];
            else if (push & is_mean & ~p_lock_q)
                press_q <= avg_val;
            else if (press_strobe & is_bypass & ~p_lock_q)
                press_q <= press_sample;
            if (temp_strobe & ~t_lock_q)
                temp_q <= temp_sample;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample queue.
    // Storage has no reset; pointers and level define what is valid.
    always @(posedge sys_clk) begin
        if (push)
            mem[wr_ptr_q] <= press_sample;
    end

    always @(posedge sys_clk) begin
        if (!rst_b) begin
            wr_ptr_q    <= {DEPTH_LOG2{1'b0}};
            rd_ptr_q    <= {DEPTH_LOG2{1'b0}};
            count_q     <= {(DEPTH_LOG2+1){1'b0}};
            sum_q       <= {SW{1'b0}};
            prev_mode_q <= `PRFIR_M_BYPASS;
        end else begin
            prev_mode_q <= mode_now;
            if (flush) begin
                wr_ptr_q <= {DEPTH_LOG2{1'b0}};
                rd_ptr_q <= {DEPTH_LOG2{1'b0}};
                count_q  <= {(DEPTH_LOG2+1){1'b0}};
                sum_q    <= {SW{1'b0}};
            end else begin
                if (push)
                    wr_ptr_q <= wr_ptr_q + 1'b1;
                if (pop | drop)
                    rd_ptr_q <= rd_ptr_q + 1'b1;
                if (push & ~pop & ~full)
                    count_q <= count_q + 1'b1;
                else if (pop & ~push)
                    count_q <= count_q - 1'b1;
                if (push & is_mean)
                    sum_q <= sum_nx;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read data, one cycle after the read strobe.
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            reg_rdata  <= 8'h00;
            burst_wrap <= 1'b0;
        end else begin
            burst_wrap <= q_read_on;
            if (reg_rd) begin
                case (reg_addr)
                    `PRFIR_IRQ_ROUTE:    reg_rdata <= {4'h0, route_q};
                    `PRFIR_DIFF_CFG:     reg_rdata <= {5'h00, diff_cfg_q};
                    `PRFIR_DIFF_FLAGS:
                        reg_rdata <= {5'h00, diff_flags_q};
                    `PRFIR_SAMPLE_FLAGS:
                        reg_rdata <= {2'b00, p_ovr_q, t_ovr_q,
                                      2'b00, p_avail_q, t_avail_q};
                    `PRFIR_PRESS_B0:
                        reg_rdata <= pop ? mem[rd_ptr_q][7:0]
                                         : press_q[7:0];
                    `PRFIR_PRESS_B1:     reg_rdata <= press_q[15:8];
                    `PRFIR_PRESS_B2:     reg_rdata <= press_q[23:16];
                    `PRFIR_TEMP_LO:      reg_rdata <= temp_q[7:0];
                    `PRFIR_TEMP_HI:      reg_rdata <= temp_q[15:8];
                    `PRFIR_QUEUE_CTRL:   reg_rdata <= {fmode_q, wtm_q};
                    `PRFIR_QUEUE_STATE:
                        reg_rdata <= {wtm_hit, full, empty,
                                      count_q[DEPTH_LOG2-1:0]};
                    `PRFIR_THS_LO:       reg_rdata <= ths_q[7:0];
                    `PRFIR_THS_HI:       reg_rdata <= ths_q[15:8];
                    `PRFIR_OFFSET_LO:    reg_rdata <= offset_q[7:0];
                    `PRFIR_OFFSET_HI:    reg_rdata <= offset_q[15:8];
                    default:             reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event pin.
    // Data signal mode ORs the routed queue and ready sources.
    reg ev_src;
    always @* begin
        case (irq_pin_select)
            2'b00:   ev_src = |(route_q & {empty, wtm_hit, full,
                                           p_avail_q});
            2'b01:   ev_src = diff_flags_q[`PRFIR_FLG_HIGH];
            2'b10:   ev_src = diff_flags_q[`PRFIR_FLG_LOW];
            default: ev_src = diff_flags_q[`PRFIR_FLG_HIGH] |
                              diff_flags_q[`PRFIR_FLG_LOW];
        endcase
    end

    // Open drain only drives while pulling low; push-pull always drives.
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            event_pin_o  <= 1'b0;
            event_pin_oe <= 1'b1;
        end else begin
            event_pin_o  <= ev_src ^ irq_active_low;
            event_pin_oe <= ~irq_open_drain | ~(ev_src ^ irq_active_low);
        end
    end

endmodule // prfir_top

// File: prfir_map.vh
// Register map, field positions, reset values and threshold scale for the pressure
// result, status, interrupt and sample queue block.
// Assumes it is included by bare name from the block's design files.
`ifndef PRFIR_MAP_VH
`define PRFIR_MAP_VH

// Register offsets on the device register port.
`define PRFIR_IRQ_ROUTE     8'h23
`define PRFIR_DIFF_CFG      8'h24
`define PRFIR_DIFF_FLAGS    8'h25
`define PRFIR_SAMPLE_FLAGS  8'h27
`define PRFIR_PRESS_B0      8'h28
`define PRFIR_PRESS_B1      8'h29
`define PRFIR_PRESS_B2      8'h2a
`define PRFIR_TEMP_LO       8'h2b
`define PRFIR_TEMP_HI       8'h2c
`define PRFIR_QUEUE_CTRL    8'h2e
`define PRFIR_QUEUE_STATE   8'h2f
`define PRFIR_THS_LO        8'h30
`define PRFIR_THS_HI        8'h31
`define PRFIR_OFFSET_LO     8'h39
`define PRFIR_OFFSET_HI     8'h3a

// Reset values.
`define PRFIR_PRESS_RST     24'h02f800
`define PRFIR_OFFSET_LO_RST 8'h38
`define PRFIR_OFFSET_HI_RST 8'h00

// Field positions.
`define PRFIR_CFG_LATCH     2
`define PRFIR_CFG_LOW_EN    1
`define PRFIR_CFG_HIGH_EN   0
`define PRFIR_FLG_ANY       2
`define PRFIR_FLG_LOW       1
`define PRFIR_FLG_HIGH      0
`define PRFIR_ST_P_OVR      5
`define PRFIR_ST_T_OVR      4
`define PRFIR_ST_P_AVAIL    1
`define PRFIR_ST_T_AVAIL    0
`define PRFIR_QS_WTM        7
`define PRFIR_QS_FULL       6
`define PRFIR_QS_EMPTY      5

// Queue mode codes (bits 7 to 5 of queue_control).
`define PRFIR_M_BYPASS      3'b000
`define PRFIR_M_FIFO        3'b001
`define PRFIR_M_STREAM      3'b010
`define PRFIR_M_STR_FIFO    3'b011
`define PRFIR_M_BYP_STR     3'b100
`define PRFIR_M_MEAN        3'b110
`define PRFIR_M_BYP_FIFO    3'b111

// Pressure counts per threshold count: 4096 per hPa over 16 per hPa.
`define PRFIR_THS_SHIFT     8

`endif

// File: prfir_monitor.sv
// Checker on the ports of prfir_top.
// Assumes one sys_clk domain and the synchronous active-low reset.
`timescale 1ns/10ps
module prfir_monitor (
    // Clock and reset.
    input wire       sys_clk,
    input wire       rst_b,
    // Register port.
    input wire [7:0] reg_addr,
    input wire       reg_wr,
    input wire [7:0] reg_wdata,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       burst_wrap,
    // Samples and event pin.
    input wire       press_strobe,
    input wire       irq_open_drain,
    input wire       event_pin_o,
    input wire       event_pin_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Reads with no sample beside them, so a set cannot mask a clear.
    sequence s_top; reg_rd && reg_addr == 8'h2a && !press_strobe; endsequence
    sequence s_sta; reg_rd && reg_addr == 8'h27 && !press_strobe; endsequence
    sequence s_flg; reg_rd && reg_addr == 8'h25 && !press_strobe; endsequence
    property p_pclr; s_top ##1 !press_strobe ##1 s_sta |=>
        {reg_rdata[5], reg_rdata[1]} == 2'b00; endproperty
    a_pclr: assert property (p_pclr) else $error("status kept");
    property p_fclr; !$past(press_strobe) ##0 s_flg ##1 !press_strobe
        ##1 s_flg |=> reg_rdata == 8'h00; endproperty
    a_fclr: assert property (p_fclr) else $error("flags kept");
    property p_frsv; reg_rd && reg_addr == 8'h25 |=>
        reg_rdata[7:3] == 5'h00; endproperty
    a_frsv: assert property (p_frsv) else $error("flag bits set");
    property p_pav; press_strobe ##1 !(reg_rd && reg_addr == 8'h2a)
        ##1 s_sta |=> reg_rdata[1]; endproperty
    a_pav: assert property (p_pav) else $error("no available");
    property p_wrap; reg_wr && reg_addr == 8'h2e && reg_wdata[7:5] == 3'b001
        |-> ##[1:2] burst_wrap; endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");
    property p_qst; reg_rd && reg_addr == 8'h2f |=> reg_rdata[5] ==
        (reg_rdata[4:0] == 5'h00 && !reg_rdata[6]); endproperty
    a_qst: assert property (p_qst) else $error("empty bit wrong");
    // Push-pull drives always; open drain never drives high.
    property p_pp; !irq_open_drain ##1 !irq_open_drain |-> event_pin_oe;
    endproperty
    a_pp: assert property (p_pp) else $error("pin undriven");
    property p_od; irq_open_drain ##1 irq_open_drain |->
        !(event_pin_oe && event_pin_o); endproperty
    a_od: assert property (p_od) else $error("pin driven high");
endmodule // prfir_monitor

bind prfir_top prfir_monitor mon_u (.sys_clk, .rst_b, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .burst_wrap, .press_strobe,
    .irq_open_drain, .event_pin_o, .event_pin_oe);

// File: prfir_host.sv
// Host controller model driving the device register port.
// Assumes one access at a time, launched just after a rising edge.
`timescale 1ns/10ps
module prfir_host (
    // Clock.
    input wire            sys_clk,
    // Register port.
    output reg      [7:0] reg_addr = 8'h00,
    output reg            reg_wr = 1'b0,
    output reg      [7:0] reg_wdata = 8'h00,
    output reg            reg_rd = 1'b0,
    input wire      [7:0] reg_rdata
);
    // Released lines show the inverse, so no stale value reads as valid.
    task wr(input [7:0] a, input [7:0] v);
        begin
            @(posedge sys_clk); #1 reg_addr = a; reg_wdata = v; reg_wr = 1;
            @(posedge sys_clk); #1 reg_wr = 0; reg_addr = ~a; reg_wdata = ~v;
        end
    endtask
    task rd(input [7:0] a, output [7:0] v);
        begin
            @(posedge sys_clk); #1 reg_addr = a; reg_rd = 1;
            @(posedge sys_clk); #1 v = reg_rdata; reg_rd = 0; reg_addr = ~a;
        end
    endtask
endmodule // prfir_host

// File: prfir_top_tb.sv
// Self-checking bench for prfir_top, driven through the host model.
// Assumes the bound checker and a 4 ns sys_clk.
`timescale 1ns/10ps
module prfir_top_tb;
    reg         sys_clk = 0, rst_b = 0, press_strobe = 0, temp_strobe = 0;
    reg         differential_enable = 0, hold_until_both_read = 0;
    reg         irq_active_low = 0, irq_open_drain = 0, trigger_pin = 1;
    reg  [1:0]  irq_pin_select = 0;
    reg  [23:0] press_sample = 0;
    reg  [15:0] temp_sample = 0;
    wire [7:0]  reg_addr, reg_wdata, reg_rdata;
    wire        reg_wr, reg_rd, burst_wrap, event_pin_o, event_pin_oe;
    integer     num_errors = 0, comparisons = 0, k, j;
    reg  [7:0]  d;
    initial forever #2 sys_clk = ~sys_clk;
    prfir_top dut_u (.sys_clk, .rst_b, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .burst_wrap, .press_strobe, .press_sample,
        .temp_strobe, .temp_sample, .differential_enable,
        .hold_until_both_read, .irq_active_low, .irq_open_drain,
        .irq_pin_select, .trigger_pin, .event_pin_o, .event_pin_oe);
    prfir_host h (.sys_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata);
    // One compare for every byte-wide result.
    task chk(input string n, input [7:0] e, input [7:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("Error %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task rc(input [7:0] a, input [7:0] e);
        begin h.rd(a, d); chk($sformatf("reg_%h", a), e, d); end
    endtask
    task samp(input [23:0] v);
        begin
            @(posedge sys_clk); #1 press_sample = v; press_strobe = 1;
            @(posedge sys_clk); #1 press_strobe = 0;
        end
    endtask
    task end_sim;
        begin
            $display("comparisons %0d errors %0d", comparisons, num_errors);
            if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // A hang costs a mismatch; the tests need under 10 us.
    initial begin #100000; num_errors = num_errors + 1; end_sim; end
    initial begin
        repeat (8) @(posedge sys_clk);
        #1 rst_b = 1;
        rc(8'h28, 8'h00); rc(8'h29, 8'hf8); rc(8'h2a, 8'h02);
        rc(8'h39, 8'h38);
        h.wr(8'h23, 8'h01); rc(8'h23, 8'h01);
        h.wr(8'h26, 8'hff); rc(8'h26, 8'h00);
        samp(24'h123456); rc(8'h27, 8'h02);
        chk("pin", 8'h01, {7'h0, event_pin_o});
        rc(8'h28, 8'h56); rc(8'h29, 8'h34); rc(8'h2a, 8'h12);
        rc(8'h27, 8'h00);
        chk("pin", 8'h00, {7'h0, event_pin_o});
        samp(0); samp(0); rc(8'h27, 8'h22);
        rc(8'h2a, 8'h00); rc(8'h27, 8'h00);
        for (k = 0; k < 2; k = k + 1) begin
            @(posedge sys_clk); #1 temp_sample = 16'hbeef; temp_strobe = 1;
            @(posedge sys_clk); #1 temp_strobe = 0;
        end
        rc(8'h27, 8'h11);
        rc(8'h2b, 8'hef); rc(8'h2c, 8'hbe); rc(8'h27, 8'h00);
        // Result held after a partial read while status keeps moving.
        hold_until_both_read = 1;
        samp(24'h110000); rc(8'h28, 8'h00); samp(24'h220000);
        rc(8'h27, 8'h22); rc(8'h2a, 8'h11);
        hold_until_both_read = 0;
        // Threshold 1/16 hPa is 256 counts; offset 38h is subtracted.
        differential_enable = 1;
        h.wr(8'h30, 8'h01);
        for (k = 0; k < 2; k = k + 1) begin
            h.wr(8'h24, {5'h0, k[0], 2'b11});
            samp(24'h000238); samp(24'h000038);
            rc(8'h25, k ? 8'h05 : 8'h00);
        end
        samp(24'hfffe38);
        for (k = 2; k < 4; k = k + 1) begin
            irq_pin_select = k[1:0]; repeat (2) @(posedge sys_clk);
            #1 chk("pin", 8'h01, {7'h0, event_pin_o});
        end
        rc(8'h25, 8'h06); rc(8'h25, 8'h00);
        h.wr(8'h24, 8'h04); samp(24'h000238); samp(24'hfffe38);
        rc(8'h25, 8'h00);
        h.wr(8'h24, 8'h07); differential_enable = 0; samp(24'h000238);
        rc(8'h25, 8'h00);
        differential_enable = 1; irq_pin_select = 2'b01; samp(24'h000238);
        repeat (2) @(posedge sys_clk);
        #1 chk("pin", 8'h01, {7'h0, event_pin_o});
        irq_active_low = 1; irq_open_drain = 1;
        repeat (2) @(posedge sys_clk);
        #1 chk("pin", 8'h01, {6'h0, event_pin_o, event_pin_oe});
        rc(8'h25, 8'h05); repeat (3) @(posedge sys_clk);
        #1 chk("pin_oe", 8'h00, {7'h0, event_pin_oe});
        irq_active_low = 0; irq_open_drain = 0; irq_pin_select = 0;
        // Queue keeps oldest when full; stream drops the oldest.
        for (k = 0; k < 4; k = k + 1) begin
            trigger_pin = (k != 3);
            h.wr(8'h2e, 8'h00);
            h.wr(8'h2e, k == 3 ? 8'he2 : 8'h22 + 8'h20 * k[7:0]);
            for (j = 0; j < 33; j = j + 1) begin
                samp(j[23:0]);
                if (j < 2) rc(8'h2f, j ? 8'h82 : 8'h01);
            end
            rc(8'h2f, 8'hc0);
            chk("wrap", 8'h01, {7'h0, burst_wrap});
            rc(8'h28, {7'h0, (k == 1 || k == 2)}); rc(8'h2f, 8'h9f);
        end
        trigger_pin = 1;
        h.wr(8'h2e, 8'h00); h.wr(8'h2e, 8'hc1); samp(100); samp(300);
        rc(8'h28, 8'hc8); rc(8'h28, 8'hc8);
        h.wr(8'h2e, 8'h00); h.wr(8'h2e, 8'h80); samp(0);
        rc(8'h2f, 8'ha0);
        trigger_pin = 0; repeat (4) @(posedge sys_clk);
        samp(0); samp(0); rc(8'h2f, 8'h82);
        end_sim;
    end
endmodule // prfir_top_tb
